//--- design/acm_ctrl.sv
// Control logic for four analog comparators: config, thresholds, edge flags
//
// Function
// - Two config registers, four fields per comparator
// - Config registers reset to all zeros
// - Comparator A picks first or second reference
// - B, C, D pick first or external reference
// - Interrupt enable gates each comparator's request
// - Polarity bit inverts output before use
// - First threshold code drives 256-step DAC
// - Live outputs readable without latching
// - Any output edge can raise interrupt
// - Sticky flag per comparator, software clears
// - Disabled comparator reports low
// - Second threshold code drives second DAC
`timescale 1ns/100ps
`default_nettype none

module acm_ctrl (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	// CPU register port
	input  wire logic [15:0] addr_in,
	input  wire logic [7:0]  wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output var  logic [7:0]  rdata_out,
	// Raw comparator outputs, bit 0 is comparator A
	input  wire logic [3:0]  cmp_raw_in,
	// Analog controls
	output var  logic [3:0]  cmp_on_out,
	output var  logic [7:0]  ref_sel_out,
	output var  logic [7:0]  dac0_code_out,
	output var  logic [7:0]  dac1_code_out,
	output var  logic [1:0]  hyst_a_out,
	output var  logic [1:0]  hyst_bcd_out,
	// CPU interrupt request
	output var  logic        irq_out
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	acm_pkg::acm_bus_s bus;
	acm_pkg::acm_cfg_s cfg [4];
	logic [7:0]        th0;
	logic [7:0]        th1;
	logic [1:0]        hys_a;
	logic [1:0]        hys_b;
	logic [3:0]        stable;
	logic [3:0]        live;
	logic [3:0]        next_live;
	logic [3:0]        flag;
	logic [3:0]        cmp_set;
	logic [3:0]        cmp_clr;
	logic [3:0]        irq_on;
	logic [7:0]        next_rdata;
	logic              wr_ab;
	logic              wr_cd;
	logic              wr_th0;
	logic              wr_th1;
	logic              wr_state;

	assign bus.addr  = addr_in;
	assign bus.wdata = wdata_in;
	assign bus.wr    = wr_in;
	assign bus.rd    = rd_in;

	assign wr_ab    = bus.wr && (bus.addr == acm_pkg::OFS_CFG_AB);
	assign wr_cd    = bus.wr && (bus.addr == acm_pkg::OFS_CFG_CD);
	assign wr_th0   = bus.wr && (bus.addr == acm_pkg::OFS_TH0);
	assign wr_th1   = bus.wr && (bus.addr == acm_pkg::OFS_TH1);
	assign wr_state = bus.wr && (bus.addr == acm_pkg::OFS_STATE);

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	// Upper nibble is A (or C), lower nibble is B (or D)
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			{cfg[0], cfg[1]} <= acm_pkg::RST_CFG;
			{cfg[2], cfg[3]} <= acm_pkg::RST_CFG;
		end else begin
			if (wr_ab) begin
				{cfg[0], cfg[1]} <= bus.wdata;
			end
			if (wr_cd) begin
				{cfg[2], cfg[3]} <= bus.wdata;
			end
		end
	end

	// ****************************************************************
	// Threshold codes
	// ****************************************************************
	// Code 00 gives 0 V, ff the full 1.8 V scale; zero also saves power
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			th0 <= acm_pkg::RST_TH;
			th1 <= acm_pkg::RST_TH;
		end else begin
			if (wr_th0) begin
				th0 <= bus.wdata;
			end
			if (wr_th1) begin
				th1 <= bus.wdata;
			end
		end
	end

	assign dac0_code_out = th0;
	assign dac1_code_out = th1;

	// ****************************************************************
	// Hysteresis, write side of the state register
	// ****************************************************************
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			hys_a <= acm_pkg::RST_HYS;
			hys_b <= acm_pkg::RST_HYS;
		end else if (wr_state) begin
			hys_a <= bus.wdata[acm_pkg::HYS_A_LSB +: acm_pkg::HYS_W];
			hys_b <= bus.wdata[acm_pkg::HYS_B_LSB +: acm_pkg::HYS_W];
		end
	end

	assign hyst_a_out   = hys_a;
	assign hyst_bcd_out = hys_b;

	// ****************************************************************
	// Synchroniser
	// ****************************************************************
	// Analog outputs are asynchronous; a glitch must not give two flags
	acm_sync u_sync (
		.clk_in     (clk_in),
		.rst_n_in   (rst_n_in),
		.raw_in     (cmp_raw_in),
		.stable_out (stable)
	);

	// ****************************************************************
	// Per comparator datapath
	// ****************************************************************
	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_cmp
			assign cmp_on_out[i] = cfg[i].on;
			assign irq_on[i]     = cfg[i].irq_on;

			// Polarity applied first, then off forces low
			assign next_live[i] = cfg[i].on & (stable[i] ^ cfg[i].invert);

			// Polarity changes, or switching on while the output is high, also toggle the output and flag; switching off drops the output without a flag
			assign cmp_set[i] = cfg[i].on && (next_live[i] != live[i]);
			assign cmp_clr[i] = wr_state && !bus.wdata[acm_pkg::FLAG_LSB + i];

			always_ff @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					live[i] <= 1'b0;
				end else begin
					live[i] <= next_live[i];
				end
			end

			// A new edge beats a clear in the same cycle
			always_ff @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					flag[i] <= 1'b0;
				end else if (cmp_set[i]) begin
					flag[i] <= 1'b1;
				end else if (cmp_clr[i]) begin
					flag[i] <= 1'b0;
				end
			end

			// Only A can reach the second DAC; the others share one pin
			always_ff @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					ref_sel_out[2*i +: 2] <= acm_pkg::REF_FIRST;
				end else if (!cfg[i].ref_pick) begin
					ref_sel_out[2*i +: 2] <= acm_pkg::REF_FIRST;
				end else if (i == 0) begin
					ref_sel_out[2*i +: 2] <= acm_pkg::REF_SECOND;
				end else begin
					ref_sel_out[2*i +: 2] <= acm_pkg::REF_EXT;
				end
			end

			// ****************************************************************
			// Per comparator checks
			// ****************************************************************
			a_off_reads_low : assert property (
				@(posedge clk_in) disable iff (!rst_n_in)
				!cfg[i].on |=> !live[i]
			) else $error("disabled comparator reports high");

			a_polarity_applied : assert property (
				@(posedge clk_in) disable iff (!rst_n_in)
				cfg[i].on |=> (live[i] == ($past(stable[i]) ^ $past(cfg[i].invert)))
			) else $error("reported output ignores polarity");

			a_edge_sets_flag : assert property (
				@(posedge clk_in) disable iff (!rst_n_in)
				(cfg[i].on && (next_live[i] != live[i])) |=> flag[i]
			) else $error("output edge did not set flag");

			a_flag_sticky : assert property (
				@(posedge clk_in) disable iff (!rst_n_in)
				(flag[i] && !cmp_clr[i]) |=> flag[i]
			) else $error("flag dropped without software clear");
		end
	endgenerate

	// ****************************************************************
	// Interrupt request
	// ****************************************************************
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(flag & irq_on);
		end
	end

	// ****************************************************************
	// Read port
	// ****************************************************************
	// Unmapped addresses read zero; data stand one cycle only
	always_comb begin
		next_rdata = acm_pkg::RST_RDATA;
		if (bus.rd) begin
			unique case (bus.addr)
				acm_pkg::OFS_CFG_AB: next_rdata = {cfg[0], cfg[1]};
				acm_pkg::OFS_CFG_CD: next_rdata = {cfg[2], cfg[3]};
				acm_pkg::OFS_TH0:    next_rdata = th0;
				acm_pkg::OFS_TH1:    next_rdata = th1;
				acm_pkg::OFS_STATE:  next_rdata = {flag, live};
				default:             next_rdata = acm_pkg::RST_RDATA;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_out <= acm_pkg::RST_RDATA;
		end else begin
			rdata_out <= next_rdata;
		end
	end

	// ****************************************************************
	// Block level checks
	// ****************************************************************
	a_cfg_write_lands : assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		wr_ab |=> ({cfg[0], cfg[1]} == $past(wdata_in))
	) else $error("config write not stored");

	a_cfg_reads_back : assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		(rd_in && (addr_in == acm_pkg::OFS_CFG_CD))
			|=> (rdata_out == {$past(cfg[2]), $past(cfg[3])})
	) else $error("config read mismatch");

	a_ref_a_route : assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		cfg[0].ref_pick |=> (ref_sel_out[1:0] == acm_pkg::REF_SECOND)
	) else $error("comparator A not on second reference");

	a_ref_b_route : assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		##1 (ref_sel_out[3:2] == ($past(cfg[1].ref_pick)
			? acm_pkg::REF_EXT : acm_pkg::REF_FIRST))
	) else $error("comparator B reference route wrong");

	a_dac_code_write : assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		wr_th0 |=> (dac0_code_out == $past(wdata_in))
	) else $error("first threshold code not applied");

	a_dac_second : assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		wr_th1 |=> (dac1_code_out == $past(wdata_in))
	) else $error("second threshold code not applied");

	a_irq_gated : assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		!(|(flag & irq_on)) |=> !irq_out
	) else $error("interrupt without enabled flag");

	a_irq_raised : assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		(|(flag & irq_on)) |=> irq_out
	) else $error("enabled flag gave no interrupt");

	a_live_readable : assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		(rd_in && (addr_in == acm_pkg::OFS_STATE))
			|=> (rdata_out[3:0] == $past(live))
	) else $error("state read does not show live outputs");

	a_read_one_cycle : assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		!rd_in |=> (rdata_out == acm_pkg::RST_RDATA)
	) else $error("read data outside its cycle");

endmodule

`default_nettype wire

//--- design/acm_pkg.sv
// Register map, field layout and types for the analog comparator control
package acm_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int unsigned NUM_CMP = 4;
	localparam int unsigned ADDR_W  = 16;
	localparam int unsigned DATA_W  = 8;
	localparam int unsigned HYS_W   = 2;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [15:0] OFS_CFG_AB = 16'ha030;
	localparam logic [15:0] OFS_CFG_CD = 16'ha031;
	localparam logic [15:0] OFS_TH0    = 16'ha032;
	localparam logic [15:0] OFS_TH1    = 16'ha033;
	localparam logic [15:0] OFS_STATE  = 16'h0094;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] RST_CFG   = 8'h00;
	localparam logic [7:0] RST_TH    = 8'h00;
	localparam logic [7:0] RST_RDATA = 8'h00;
	localparam logic [1:0] RST_HYS   = 2'h0;

	// ****************************************************************
	// Field positions in the state register
	// ****************************************************************
	localparam int unsigned LIVE_LSB  = 0;
	localparam int unsigned FLAG_LSB  = 4;
	localparam int unsigned HYS_A_LSB = 0;
	localparam int unsigned HYS_B_LSB = 2;

	// ****************************************************************
	// Types
	// ****************************************************************
	// One nibble of a config register, msb first: on, pick, irq, invert
	typedef struct packed {
		logic on;
		logic ref_pick;
		logic irq_on;
		logic invert;
	} acm_cfg_s;

	// Threshold route handed to each comparator's analog mux
	typedef enum logic [1:0] {
		REF_FIRST  = 2'b00,
		REF_SECOND = 2'b01,
		REF_EXT    = 2'b10
	} acm_ref_e;

	// One register access from the CPU side
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} acm_bus_s;

endpackage

//--- design/acm_sync.sv
// Three-stage synchroniser with agreement filter for the comparator outputs
`timescale 1ns/100ps
`default_nettype none

module acm_sync (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	// Asynchronous comparator outputs
	input  wire logic [3:0] raw_in,
	// Settled levels in the clock domain
	output var  logic [3:0] stable_out
);

	// ****************************************************************
	// Stages
	// ****************************************************************
	logic [3:0] stage1;
	logic [3:0] stage2;
	logic [3:0] stage3;

	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_bit
			// Stage one feeds only stage two, metastability stays put
			always_ff @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					stage1[i]     <= 1'b0;
					stage2[i]     <= 1'b0;
					stage3[i]     <= 1'b0;
					stable_out[i] <= 1'b0;
				end else begin
					stage1[i] <= raw_in[i];
					stage2[i] <= stage1[i];
					stage3[i] <= stage2[i];
					// One settled change per transition
					if (stage2[i] == stage3[i]) begin
						stable_out[i] <= stage3[i];
					end
				end
			end

			// ****************************************************************
			// Checks
			// ****************************************************************
			a_sync_agree : assert property (
				@(posedge clk_in) disable iff (!rst_n_in)
				(stable_out[i] != $past(stable_out[i]))
					|-> ($past(stage2[i]) == $past(stage3[i]))
			) else $error("settled level changed without agreement");
		end
	endgenerate

endmodule

`default_nettype wire

//--- tb/acm_cmp_model.sv
// Behavioural model of the four comparators and their threshold DACs
`timescale 1ns/100ps
`default_nettype none

module acm_cmp_model (
	// Clock for the idle pattern
	input  wire logic        clk_in,
	// Controls from the block
	input  wire logic [3:0]  cmp_on_in,
	input  wire logic [7:0]  ref_sel_in,
	input  wire logic [7:0]  dac0_in,
	input  wire logic [7:0]  dac1_in,
	// Analog levels as DAC-step codes, byte i is comparator i
	input  wire logic [31:0] vin_in,
	input  wire logic [7:0]  ext_in,
	// Raw outputs
	output var  logic [3:0]  raw_out
);
	logic       wiggle;
	logic [7:0] thr [4];

	initial wiggle = 1'b0;
	always @(posedge clk_in) wiggle <= ~wiggle;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			case (ref_sel_in[2*i +: 2])
				2'b01:   thr[i] = dac1_in;
				2'b10:   thr[i] = ext_in;
				default: thr[i] = dac0_in;
			endcase
			// An unpowered comparator output is not trusted to hold
			raw_out[i] = cmp_on_in[i] ? (vin_in[8*i +: 8] > thr[i]) : wiggle;
		end
	end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking testbench for the comparator control block
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	// ****************************************************************
	// Signals
	// ****************************************************************
	logic        clk_in;
	logic        rst_n_in;
	logic [15:0] addr_in;
	logic [7:0]  wdata_in;
	logic        wr_in;
	logic        rd_in;
	logic [7:0]  rdata_out;
	logic [3:0]  cmp_raw_in;
	logic [3:0]  cmp_on_out;
	logic [7:0]  ref_sel_out;
	logic [7:0]  dac0_code_out;
	logic [7:0]  dac1_code_out;
	logic [1:0]  hyst_a_out;
	logic [1:0]  hyst_bcd_out;
	logic        irq_out;
	logic [31:0] vin;
	logic [7:0]  ext;
	logic [7:0]  d;
	int          mismatches;
	int          n_checks;
	// Rows: cfg ab, cfg cd, th0, th1, enables, routes
	localparam logic [47:0] CFG_ROWS [4] = '{48'h0000_0000_0000,
		48'hc000_ff01_0101, 48'h4ccc_80ff_0ea9, 48'h0044_ff00_00a0};
	// Rows: cfg ab, cfg cd, live nibble (th0 80, th1 20, ext 10)
	localparam logic [23:0] LIVE_ROWS [5] = '{24'h8888_04,
		24'hc8cc_0d, 24'h9999_0b, 24'h0000_00, 24'hc000_01};

	acm_ctrl DUT (
		.clk_in        (clk_in),
		.rst_n_in      (rst_n_in),
		.addr_in       (addr_in),
		.wdata_in      (wdata_in),
		.wr_in         (wr_in),
		.rd_in         (rd_in),
		.rdata_out     (rdata_out),
		.cmp_raw_in    (cmp_raw_in),
		.cmp_on_out    (cmp_on_out),
		.ref_sel_out   (ref_sel_out),
		.dac0_code_out (dac0_code_out),
		.dac1_code_out (dac1_code_out),
		.hyst_a_out    (hyst_a_out),
		.hyst_bcd_out  (hyst_bcd_out),
		.irq_out       (irq_out)
	);

	acm_cmp_model MODEL (
		.clk_in     (clk_in),
		.cmp_on_in  (cmp_on_out),
		.ref_sel_in (ref_sel_out),
		.dac0_in    (dac0_code_out),
		.dac1_in    (dac1_code_out),
		.vin_in     (vin),
		.ext_in     (ext),
		.raw_out    (cmp_raw_in)
	);

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= v;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
		#1;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [15:0] a);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic end_of_test;
		if (mismatches == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ****************************************************************
	// Clock, reset and watchdog
	// ****************************************************************
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	initial begin
		#300us;
		mismatches++;
		end_of_test();
	end

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		rst_n_in = 1'b0;
		addr_in = 16'h0000;
		wdata_in = 8'h00;
		wr_in = 1'b0;
		rd_in = 1'b0;
		// Pins are analog-connected with drivers off
		vin = 32'h40c0_4040;
		ext = 8'h10;
		mismatches = 0;
		n_checks = 0;
		repeat (4) @(posedge clk_in);
		rst_n_in <= 1'b1;
		#1;
		chk({4'h0, cmp_on_out}, 8'h00);
		chk(ref_sel_out, 8'h00);
		rd(16'ha030);
		chk(d, 8'h00);
		rd(16'ha031);
		chk(d, 8'h00);
		foreach (CFG_ROWS[i]) begin
			wr(16'ha030, CFG_ROWS[i][47:40]);
			wr(16'ha031, CFG_ROWS[i][39:32]);
			wr(16'ha032, CFG_ROWS[i][31:24]);
			wr(16'ha033, CFG_ROWS[i][23:16]);
			rd(16'ha030);
			chk(d, CFG_ROWS[i][47:40]);
			rd(16'ha031);
			chk(d, CFG_ROWS[i][39:32]);
			chk({4'h0, cmp_on_out}, CFG_ROWS[i][15:8]);
			chk(ref_sel_out, CFG_ROWS[i][7:0]);
			chk(dac0_code_out, CFG_ROWS[i][31:24]);
			chk(dac1_code_out, CFG_ROWS[i][23:16]);
		end
		// Unmapped accesses read zero and change nothing
		wr(16'ha034, 8'hff);
		rd(16'ha034);
		chk(d, 8'h00);
		rd(16'ha033);
		chk(d, 8'h00);
		wr(16'ha032, 8'h80);
		wr(16'ha033, 8'h20);
		wr(16'ha030, 8'h88);
		wr(16'ha031, 8'h88);
		// Software lets the bias settle for 20 us
		idle(2000);
		foreach (LIVE_ROWS[i]) begin
			wr(16'ha030, LIVE_ROWS[i][23:16]);
			wr(16'ha031, LIVE_ROWS[i][15:8]);
			// The last row switches A back on, so every row waits
			idle(2000);
			rd(16'h0094);
			chk({4'h0, d[3:0]}, LIVE_ROWS[i][7:0]);
		end
		// Rising edge on A with its interrupt on
		wr(16'ha031, 8'h00);
		wr(16'ha030, 8'ha0);
		vin[7:0] <= 8'h40;
		idle(10);
		wr(16'h0094, 8'h0e);
		chk({6'h0, hyst_a_out}, 8'h02);
		chk({6'h0, hyst_bcd_out}, 8'h03);
		idle(2);
		chk({7'h0, irq_out}, 8'h00);
		vin[7:0] <= 8'hc0;
		idle(10);
		rd(16'h0094);
		chk(d, 8'h11);
		chk({7'h0, irq_out}, 8'h01);
		idle(20);
		rd(16'h0094);
		chk(d, 8'h11);
		// Clearing only flag A, then a falling edge sets it again
		wr(16'h0094, 8'he0);
		idle(2);
		chk({7'h0, irq_out}, 8'h00);
		vin[7:0] <= 8'h40;
		idle(10);
		rd(16'h0094);
		chk(d, 8'h10);
		// Interrupt enable off: flag sets, request stays low
		wr(16'h0094, 8'he0);
		wr(16'ha030, 8'h90);
		idle(10);
		rd(16'h0094);
		chk(d, 8'h11);
		chk({7'h0, irq_out}, 8'h00);
		// Disabled comparator sees a wandering raw output
		wr(16'ha030, 8'h00);
		wr(16'h0094, 8'h00);
		idle(30);
		rd(16'h0094);
		chk(d, 8'h00);
		// Unused thresholds are parked at zero
		wr(16'ha032, 8'h00);
		wr(16'ha033, 8'h00);
		idle(2);
		chk(dac0_code_out, 8'h00);
		// Reset in mid-run clears config, codes, flags and request
		wr(16'ha030, 8'hff);
		wr(16'ha033, 8'h5a);
		idle(10);
		@(posedge clk_in);
		rst_n_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		rst_n_in <= 1'b1;
		#1;
		chk({4'h0, cmp_on_out}, 8'h00);
		chk(ref_sel_out, 8'h00);
		chk(dac1_code_out, 8'h00);
		chk({7'h0, irq_out}, 8'h00);
		rd(16'ha030);
		chk(d, 8'h00);
		rd(16'h0094);
		chk(d, 8'h00);
		end_of_test();
	end
endmodule
`default_nettype wire
